// ==== logic/rtt_regs.sv ====
// Radio test and timer register block: test payload control, prefetch
// timing, coarse and precise timer compares, counter capture, control two.
// Assumes a base time counter and radio datapath on the same clock, and a
// register port with one-cycle strobes and read data one cycle later.
`timescale 1ns/1ps
`default_nettype none
`include "rtt_params.svh"
module rtt_regs (
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic [31:0]       reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [31:0]            reg_rdata_q,
	input  wire rtt_pkg::rtt_time_t base_time_count,
	input  wire logic              rf_test_mode,
	input  wire logic              pkt_start,
	input  wire logic              byte_req,
	input  wire logic [7:0]        descriptor_adv_len,
	input  wire logic [7:0]        mem_payload_byte,
	input  wire logic [15:0]       us_to_event,
	input  wire logic [7:0]        rssi_peak,
	input  wire logic [7:0]        rssi_avg,
	input  wire logic              lp_wake_irq,
	input  wire logic              radio_powered,
	input  wire logic              lp_clk_tick,
	output logic                   irq_q,
	output logic                   endless_rx_window_q,
	output logic                   endless_tx_payload_q,
	output logic [8:0]             tx_len_q,
	output logic [7:0]             tx_byte_q,
	output logic [8:0]             pattern_index_q,
	output logic                   prefetch_q,
	output logic [7:0]             rssi_q,
	output logic                   lp_wake_status_q
);
	import rtt_pkg::*;

	logic        tx_len_source_q;
	logic        prbs_select_q;
	logic        tx_payload_source_q;
	logic [8:0]  test_tx_len_q;
	logic [7:0]  table_prefetch_us_q;
	logic [15:0] coarse_target_q;
	rtt_time_t   precise_target_q;
	logic        capture_request_q;
	rtt_time_t   sample_q;
	logic        rssi_source_select_q;
	logic [2:0]  reserved_ctl_q;
	rtt_irq_t    sts_q;
	rtt_irq_t    sts_d;
	rtt_irq_t    en_q;
	rtt_irq_t    evt;
	rtt_wake_t   wake_st_q;
	logic        coarse_match, precise_match, prefetch_match;
	logic        coarse_match_q, precise_match_q, prefetch_match_q;
	logic        wr_rf, wr_timgen, wr_coarse, wr_precise;
	logic        wr_capture, wr_ctl2, wr_clr, wr_en;
	logic        prbs_mode;
	logic        pattern_wrap;
	logic        wake_clear;

	rtt_prbs_if p ();

	rtt_prbs_gen u_prbs (
		.clk   (clk),
		.reset (reset),
		.g     (p.gen)
	);

	// Write decode; unmapped addresses are simply ignored
	assign wr_rf      = reg_wr && (reg_addr == `RTT_RF_TEST_OFS);
	assign wr_timgen  = reg_wr && (reg_addr == `RTT_TIMGEN_OFS);
	assign wr_coarse  = reg_wr && (reg_addr == `RTT_COARSE_OFS);
	assign wr_precise = reg_wr && (reg_addr == `RTT_PRECISE_OFS);
	assign wr_capture = reg_wr && (reg_addr == `RTT_CAPTURE_OFS);
	assign wr_ctl2    = reg_wr && (reg_addr == `RTT_CTL2_OFS);
	assign wr_clr     = reg_wr && (reg_addr == `RTT_IRQ_CLR_OFS);
	assign wr_en      = reg_wr && (reg_addr == `RTT_IRQ_EN_OFS);

	// Test control register; only named fields are stored
	always_ff @(posedge clk) begin
		if (reset) begin
			endless_rx_window_q  <= 1'b0;
			endless_tx_payload_q <= 1'b0;
			tx_len_source_q      <= 1'b0;
			prbs_select_q        <= 1'b0;
			tx_payload_source_q  <= 1'b0;
			test_tx_len_q        <= 9'h000;
		end else if (wr_rf) begin
			endless_rx_window_q  <= reg_wdata[`RTT_RX_INF_BIT];
			endless_tx_payload_q <= reg_wdata[`RTT_TX_INF_BIT];
			tx_len_source_q      <= reg_wdata[`RTT_LEN_SRC_BIT];
			prbs_select_q        <= reg_wdata[`RTT_PRBS_SEL_BIT];
			tx_payload_source_q  <= reg_wdata[`RTT_PLD_SRC_BIT];
			test_tx_len_q        <= reg_wdata[`RTT_TX_LEN_MSB:0];
		end
	end

	// Prefetch and timer targets; the write decodes never overlap
	always_ff @(posedge clk) begin
		if (reset) begin
			table_prefetch_us_q <= 8'h00;
			coarse_target_q     <= 16'h0000;
			precise_target_q    <= 27'h000_0000;
		end else if (wr_timgen) begin
			table_prefetch_us_q <= reg_wdata[7:0];
		end else if (wr_coarse) begin
			coarse_target_q <= reg_wdata[15:0];
		end else if (wr_precise) begin
			precise_target_q <= reg_wdata[26:0];
		end
	end

	// Capture takes one cycle after the write, then the request drops
	always_ff @(posedge clk) begin
		if (reset) begin
			capture_request_q <= 1'b0;
			sample_q          <= 27'h000_0000;
		end else if (capture_request_q) begin
			sample_q          <= base_time_count;
			capture_request_q <= 1'b0;
		end else if (wr_capture) begin
			capture_request_q <= reg_wdata[0];
		end
	end

	// Second control register: RSSI select and keep-at-zero controls
	always_ff @(posedge clk) begin
		if (reset) begin
			rssi_source_select_q <= 1'b0;
			reserved_ctl_q       <= 3'b000;
		end else if (wr_ctl2) begin
			rssi_source_select_q <= reg_wdata[`RTT_RSSI_SEL_BIT];
			reserved_ctl_q       <= reg_wdata[`RTT_RSV_A_BIT:`RTT_RSV_C_BIT];
		end
	end

	// RSSI report follows the select bit
	always_ff @(posedge clk) begin
		if (reset) begin
			rssi_q <= 8'h00;
		end else begin
			rssi_q <= rssi_source_select_q ? rssi_avg : rssi_peak;
		end
	end

	// Compares; events fire on the first cycle of a match only, because the
	// counter holds each value for a whole 625 us tick
	assign coarse_match   = (base_time_count[`RTT_COARSE_LOW_MSB:0] == 4'h0)
		&& (base_time_count[19:4] == coarse_target_q);
	assign precise_match  = (base_time_count == precise_target_q);
	assign prefetch_match = (us_to_event == {8'h00, table_prefetch_us_q});

	always_ff @(posedge clk) begin
		if (reset) begin
			coarse_match_q   <= 1'b0;
			precise_match_q  <= 1'b0;
			prefetch_match_q <= 1'b0;
			prefetch_q       <= 1'b0;
		end else begin
			coarse_match_q   <= coarse_match;
			precise_match_q  <= precise_match;
			prefetch_match_q <= prefetch_match;
			prefetch_q       <= prefetch_match && !prefetch_match_q;
		end
	end

	// Event vector for the sticky status
	always_comb begin
		evt = '0;
		evt[`RTT_IRQ_COARSE]   = coarse_match && !coarse_match_q;
		evt[`RTT_IRQ_PRECISE]  = precise_match && !precise_match_q;
		evt[`RTT_IRQ_CAPTURE]  = capture_request_q;
		evt[`RTT_IRQ_PREFETCH] = prefetch_match && !prefetch_match_q;
	end

	// Set beats clear so an event in the clearing cycle survives
	always_comb begin
		sts_d = sts_q;
		if (wr_clr) begin
			sts_d = sts_d & ~reg_wdata[3:0];
		end
		sts_d = sts_d | evt;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			sts_q <= 4'h0;
			en_q  <= 4'h0;
			irq_q <= 1'b0;
		end else begin
			sts_q <= sts_d;
			if (wr_en) begin
				en_q <= reg_wdata[3:0];
			end
			irq_q <= |(sts_d & (wr_en ? reg_wdata[3:0] : en_q));
		end
	end

	// Wake status: set by the wake line, self-acknowledged after power up
	// and one more low-power tick; a new wake event outranks the clear
	assign wake_clear = (wake_st_q == RTT_WAKE_LP) && lp_clk_tick;

	always_ff @(posedge clk) begin
		if (reset) begin
			wake_st_q        <= RTT_WAKE_IDLE;
			lp_wake_status_q <= 1'b0;
		end else begin
			if (lp_wake_irq) begin
				lp_wake_status_q <= 1'b1;
			end else if (wake_clear) begin
				lp_wake_status_q <= 1'b0;
			end
			case (wake_st_q)
				RTT_WAKE_IDLE: begin
					if (lp_wake_irq) begin
						wake_st_q <= RTT_WAKE_PWR;
					end
				end
				RTT_WAKE_PWR: begin
					if (radio_powered) begin
						wake_st_q <= RTT_WAKE_LP;
					end
				end
				RTT_WAKE_LP: begin
					if (lp_wake_irq) begin
						wake_st_q <= RTT_WAKE_PWR;
					end else if (lp_clk_tick) begin
						wake_st_q <= RTT_WAKE_IDLE;
					end
				end
				default: wake_st_q <= RTT_WAKE_IDLE;
			endcase
		end
	end

	// Payload length: test length only counts inside RF test mode
	always_ff @(posedge clk) begin
		if (reset) begin
			tx_len_q <= 9'h000;
		end else if (rf_test_mode && tx_len_source_q) begin
			tx_len_q <= test_tx_len_q;
		end else begin
			tx_len_q <= {1'b0, descriptor_adv_len};
		end
	end

	// Generator hookup; it is reseeded at each packet start
	assign prbs_mode  = rf_test_mode && tx_payload_source_q;
	assign p.seed     = pkt_start;
	assign p.advance  = byte_req && prbs_mode;
	assign p.sel15    = prbs_select_q;

	// Memory pattern index wraps at the test length in endless mode; a length
	// of zero pins the index at zero rather than running away
	assign pattern_wrap = endless_tx_payload_q && !prbs_mode
		&& (pattern_index_q + 9'h001 >= test_tx_len_q);

	always_ff @(posedge clk) begin
		if (reset || pkt_start) begin
			pattern_index_q <= 9'h000;
		end else if (byte_req && !prbs_mode) begin
			pattern_index_q <= pattern_wrap ? 9'h000 : pattern_index_q + 9'h001;
		end
	end

	// Payload byte source
	always_ff @(posedge clk) begin
		if (reset) begin
			tx_byte_q <= 8'h00;
		end else if (byte_req) begin
			tx_byte_q <= prbs_mode ? p.pbyte : mem_payload_byte;
		end
	end

	// Read data, one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk) begin
		if (reset || !reg_rd) begin
			reg_rdata_q <= `RTT_RST_ZERO;
		end else if (reg_addr == `RTT_RF_TEST_OFS) begin
			reg_rdata_q <= {endless_rx_window_q, 15'h0000, endless_tx_payload_q,
				tx_len_source_q, prbs_select_q, tx_payload_source_q, 3'b000,
				test_tx_len_q};
		end else if (reg_addr == `RTT_TIMGEN_OFS) begin
			reg_rdata_q <= {24'h00_0000, table_prefetch_us_q};
		end else if (reg_addr == `RTT_COARSE_OFS) begin
			reg_rdata_q <= {16'h0000, coarse_target_q};
		end else if (reg_addr == `RTT_PRECISE_OFS) begin
			reg_rdata_q <= {5'h00, precise_target_q};
		end else if (reg_addr == `RTT_CAPTURE_OFS) begin
			reg_rdata_q <= {31'h0000_0000, capture_request_q};
		end else if (reg_addr == `RTT_CTL2_OFS) begin
			reg_rdata_q <= {10'h000, rssi_source_select_q, lp_wake_status_q,
				reserved_ctl_q, 17'h0_0000};
		end else if (reg_addr == `RTT_SAMPLE_OFS) begin
			reg_rdata_q <= {5'h00, sample_q};
		end else if (reg_addr == `RTT_IRQ_STS_OFS) begin
			reg_rdata_q <= {28'h000_0000, sts_q};
		end else if (reg_addr == `RTT_IRQ_EN_OFS) begin
			reg_rdata_q <= {28'h000_0000, en_q};
		end else begin
			reg_rdata_q <= `RTT_RST_ZERO;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	AST_RX_WINDOW: assert property (wr_rf |=> endless_rx_window_q == $past(reg_wdata[31]))
		else $error("endless receive bit not taken from write");
	AST_PATTERN_WRAP: assert property (
		byte_req && !prbs_mode && endless_tx_payload_q && !pkt_start
		&& pattern_index_q + 9'h001 == test_tx_len_q |=> pattern_index_q == 9'h000)
		else $error("pattern index did not wrap at test length");
	AST_TX_LEN: assert property (
		rf_test_mode && tx_len_source_q |=> tx_len_q == $past(test_tx_len_q))
		else $error("payload length not from test length field");
	AST_PLD_SRC: assert property (
		byte_req && prbs_mode |=> tx_byte_q == $past(p.pbyte))
		else $error("payload byte not from generator");
	AST_COARSE: assert property (
		evt[`RTT_IRQ_COARSE] |-> base_time_count[3:0] == 4'h0
		&& base_time_count[19:4] == coarse_target_q ##1 sts_q[`RTT_IRQ_COARSE])
		else $error("coarse event without matching counter");
	AST_PRECISE: assert property (
		$rose(precise_match) |=> sts_q[`RTT_IRQ_PRECISE])
		else $error("precise match did not set status");
	AST_CAPTURE: assert property (
		wr_capture && reg_wdata[0] && !capture_request_q |=> capture_request_q
		##1 !capture_request_q && sample_q == $past(base_time_count))
		else $error("capture did not sample counter and self clear");
	AST_RSSI: assert property (
		!rssi_source_select_q && $stable(rssi_source_select_q) |=> rssi_q == $past(rssi_peak))
		else $error("peak hold rssi not reported");
	AST_WAKE: assert property (
		wake_st_q == RTT_WAKE_LP && lp_clk_tick && !lp_wake_irq |=> !lp_wake_status_q)
		else $error("wake status not acknowledged after low power tick");
	AST_IRQ: assert property (irq_q == |(sts_q & en_q))
		else $error("interrupt level does not follow enabled status");

	COV_CAPTURE: cover property (wr_capture ##2 !capture_request_q);
	COV_COARSE: cover property (evt[`RTT_IRQ_COARSE] ##1 irq_q);
	COV_WAKE: cover property (lp_wake_irq ##[1:20] wake_clear);
endmodule
`default_nettype wire

// ==== logic/rtt_params.svh ====
// Constants of the radio test and timer register block: offsets, field
// positions, reset values, seeds and timing figures.
// Assumes inclusion by bare name from the block's modules and bench.
`ifndef RTT_PARAMS_SVH
`define RTT_PARAMS_SVH

// Register byte addresses
`define RTT_RF_TEST_OFS     32'h4000_00E0
`define RTT_TIMGEN_OFS      32'h4000_00F0
`define RTT_COARSE_OFS      32'h4000_00F4
`define RTT_PRECISE_OFS     32'h4000_00F8
`define RTT_CAPTURE_OFS     32'h4000_00FC
`define RTT_CTL2_OFS        32'h4000_0200
`define RTT_SAMPLE_OFS      32'h4000_0100
`define RTT_IRQ_STS_OFS     32'h4000_0104
`define RTT_IRQ_CLR_OFS     32'h4000_0108
`define RTT_IRQ_EN_OFS      32'h4000_010C

// Reset values
`define RTT_RST_ZERO        32'h0000_0000

// Test control field positions
`define RTT_RX_INF_BIT      31
`define RTT_TX_INF_BIT      15
`define RTT_LEN_SRC_BIT     14
`define RTT_PRBS_SEL_BIT    13
`define RTT_PLD_SRC_BIT     12
`define RTT_TX_LEN_MSB      8

// Second control register field positions
`define RTT_RSSI_SEL_BIT    21
`define RTT_WAKE_STS_BIT    20
`define RTT_RSV_A_BIT       19
`define RTT_RSV_B_BIT       18
`define RTT_RSV_C_BIT       17

// Interrupt status bit positions
`define RTT_IRQ_COARSE      0
`define RTT_IRQ_PRECISE     1
`define RTT_IRQ_CAPTURE     2
`define RTT_IRQ_PREFETCH    3

// Generator seeds
`define RTT_PRBS9_SEED      9'h1FF
`define RTT_PRBS15_SEED     15'h7FFF

// Time base: one count of the base counter, coarse compare grain
`define RTT_BASE_TICK_US    625
`define RTT_COARSE_RES_MS   10
`define RTT_COARSE_LOW_MSB  3

`endif

// ==== logic/rtt_pkg.sv ====
// Types shared by the radio test and timer register block.
// Assumes the constants header sits beside it.
`default_nettype none
package rtt_pkg;
	typedef logic [26:0] rtt_time_t;
	typedef logic [3:0]  rtt_irq_t;
	typedef enum logic [1:0] {
		RTT_WAKE_IDLE = 2'b00,
		RTT_WAKE_PWR  = 2'b01,
		RTT_WAKE_LP   = 2'b10
	} rtt_wake_t;
endpackage
`default_nettype wire

// ==== logic/rtt_prbs_if.sv ====
// Link between the register block and its payload generator.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface rtt_prbs_if;
	logic       seed;
	logic       advance;
	logic       sel15;
	logic [7:0] pbyte;
	modport gen  (input seed, input advance, input sel15, output pbyte);
	modport user (output seed, output advance, output sel15, input pbyte);
endinterface
`default_nettype wire

// ==== logic/rtt_prbs_gen.sv ====
// Payload generator: two LFSRs yielding eight bits per advance.
// Assumes seed and advance are one-cycle pulses on clk.
`timescale 1ns/1ps
`default_nettype none
`include "rtt_params.svh"
module rtt_prbs_gen (
	input wire logic clk,
	input wire logic reset,
	rtt_prbs_if.gen  g
);
	import rtt_pkg::*;

	logic [8:0]  s9_q;
	logic [14:0] s15_q;
	logic [8:0]  c9  [0:8];
	logic [14:0] c15 [0:8];
	logic [7:0]  b9;
	logic [7:0]  b15;

	// Eight shift steps ahead; the byte on offer is the next eight bits
	assign c9[0]  = s9_q;
	assign c15[0] = s15_q;
	for (genvar i = 0; i < 8; i++) begin : g_step
		assign b9[7-i]   = c9[i][8];
		assign c9[i+1]   = {c9[i][7:0], c9[i][8] ^ c9[i][4]};
		assign b15[7-i]  = c15[i][14];
		assign c15[i+1]  = {c15[i][13:0],
			c15[i][13] ^ c15[i][12] ^ c15[i][11] ^ c15[i][1] ^ c15[i][0]};
	end

	// Type select picks which sequence feeds the payload
	assign g.pbyte = g.sel15 ? b15 : b9;

	// Both registers step together so a type change mid-packet stays defined
	always_ff @(posedge clk) begin
		if (reset || g.seed) begin
			s9_q  <= `RTT_PRBS9_SEED;
			s15_q <= `RTT_PRBS15_SEED;
		end else if (g.advance) begin
			s9_q  <= c9[8];
			s15_q <= c15[8];
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	AST_PRBS9_SEED: assert property (g.seed |=> s9_q == `RTT_PRBS9_SEED)
		else $error("prbs9 not seeded with all ones");
	AST_PRBS15_SEED: assert property (g.seed |=> s15_q == `RTT_PRBS15_SEED)
		else $error("prbs15 not seeded with all ones");
	COV_PRBS_RUN: cover property (g.seed ##1 g.advance [*3]);
endmodule
`default_nettype wire

// ==== tb/rtt_regs_bench.sv ====
// Self-checking bench for the radio test and timer register block.
// Assumes the design sources under logic/ and the constants header on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "rtt_params.svh"
module rtt_regs_bench;
	import rtt_pkg::*;

	logic             clk;
	logic             reset;
	logic [31:0]      reg_addr;
	logic [31:0]      reg_wdata;
	logic             reg_wr;
	logic             reg_rd;
	logic [31:0]      reg_rdata_q;
	rtt_time_t        base_time_count;
	logic             rf_test_mode;
	logic             pkt_start;
	logic             byte_req;
	logic [7:0]       descriptor_adv_len;
	logic [7:0]       mem_payload_byte;
	logic [15:0]      us_to_event;
	logic [7:0]       rssi_peak;
	logic [7:0]       rssi_avg;
	logic             lp_wake_irq;
	logic             radio_powered;
	logic             lp_clk_tick;
	logic             irq_q;
	logic             endless_rx_window_q;
	logic             endless_tx_payload_q;
	logic [8:0]       tx_len_q;
	logic [7:0]       tx_byte_q;
	logic [8:0]       pattern_index_q;
	logic             prefetch_q;
	logic [7:0]       rssi_q;
	logic             lp_wake_status_q;
	int               bad_count;
	int               cmp_count;
	int               cycles;
	int               pulses;
	logic [8:0]       m9;
	logic [14:0]      m15;
	logic [31:0]      rdv;
	int               polls;

	rtt_regs dut (
		.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.base_time_count(base_time_count), .rf_test_mode(rf_test_mode),
		.pkt_start(pkt_start), .byte_req(byte_req),
		.descriptor_adv_len(descriptor_adv_len), .mem_payload_byte(mem_payload_byte),
		.us_to_event(us_to_event), .rssi_peak(rssi_peak), .rssi_avg(rssi_avg),
		.lp_wake_irq(lp_wake_irq), .radio_powered(radio_powered),
		.lp_clk_tick(lp_clk_tick), .irq_q(irq_q),
		.endless_rx_window_q(endless_rx_window_q),
		.endless_tx_payload_q(endless_tx_payload_q), .tx_len_q(tx_len_q),
		.tx_byte_q(tx_byte_q), .pattern_index_q(pattern_index_q),
		.prefetch_q(prefetch_q), .rssi_q(rssi_q), .lp_wake_status_q(lp_wake_status_q)
	);

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Hang guard: whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			bad_count = bad_count + 1;
			test_done();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count = cmp_count + 1;
		if (seen !== exp) begin
			bad_count = bad_count + 1;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// One-cycle write strobe, released at the following edge
	task automatic wr(input logic [31:0] addr, input logic [31:0] data);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= addr;
		reg_wdata <= data;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe edge
	task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= addr;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1;
		chk(reg_rdata_q, exp);
	endtask

	// Plain read for polling loops; data taken in the cycle they stand
	task automatic rd_val(input logic [31:0] addr, output logic [31:0] data);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= addr;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1;
		data = reg_rdata_q;
	endtask

	// Reference generator, stepped independently of the design
	function automatic logic [7:0] ref_byte(input logic sel15);
		logic [7:0] b;
		b = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (sel15) begin
				b   = {b[6:0], m15[14]};
				m15 = {m15[13:0], m15[13] ^ m15[12] ^ m15[11] ^ m15[1] ^ m15[0]};
			end else begin
				b  = {b[6:0], m9[8]};
				m9 = {m9[7:0], m9[8] ^ m9[4]};
			end
		end
		return b;
	endfunction

	task automatic req_byte();
		@(posedge clk);
		byte_req <= 1'b1;
		@(posedge clk);
		byte_req <= 1'b0;
		#1;
	endtask

	task automatic new_packet();
		@(posedge clk);
		pkt_start <= 1'b1;
		@(posedge clk);
		pkt_start <= 1'b0;
		m9  = `RTT_PRBS9_SEED;
		m15 = `RTT_PRBS15_SEED;
	endtask

	task automatic end_test(input string name);
		$display("test %s finished, %0d compares so far", name, cmp_count);
	endtask

	task automatic test_done();
		$display("compares %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		bad_count = 0; cmp_count = 0; cycles = 0;
		reset = 1'b1; reg_addr = 32'h0000_0000; reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0; reg_rd = 1'b0; base_time_count = 27'h000_0005;
		rf_test_mode = 1'b0; pkt_start = 1'b0; byte_req = 1'b0;
		descriptor_adv_len = 8'h25; mem_payload_byte = 8'h3C; us_to_event = 16'hFFFF;
		rssi_peak = 8'h5A; rssi_avg = 8'hA5; lp_wake_irq = 1'b0;
		radio_powered = 1'b0; lp_clk_tick = 1'b0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;

		// Reset values, then full-ones writes show which bits exist
		rd_chk(`RTT_RF_TEST_OFS, 32'h0000_0000);
		rd_chk(`RTT_TIMGEN_OFS, 32'h0000_0000);
		rd_chk(`RTT_COARSE_OFS, 32'h0000_0000);
		rd_chk(`RTT_PRECISE_OFS, 32'h0000_0000);
		rd_chk(`RTT_CAPTURE_OFS, 32'h0000_0000);
		rd_chk(`RTT_CTL2_OFS, 32'h0000_0000);
		wr(`RTT_RF_TEST_OFS, 32'hFFFF_FFFF);
		rd_chk(`RTT_RF_TEST_OFS, 32'h8000_F1FF);
		chk({endless_rx_window_q, endless_tx_payload_q}, 2'b11);
		wr(`RTT_TIMGEN_OFS, 32'hFFFF_FFFF);
		rd_chk(`RTT_TIMGEN_OFS, 32'h0000_00FF);
		wr(`RTT_COARSE_OFS, 32'hFFFF_FFFF);
		rd_chk(`RTT_COARSE_OFS, 32'h0000_FFFF);
		wr(`RTT_PRECISE_OFS, 32'hFFFF_FFFF);
		rd_chk(`RTT_PRECISE_OFS, 32'h07FF_FFFF);
		wr(`RTT_CTL2_OFS, 32'hFFFF_FFFF);
		rd_chk(`RTT_CTL2_OFS, 32'h002E_0000);
		chk(rssi_q, 8'hA5);
		wr(`RTT_CTL2_OFS, 32'h0000_0000);
		wait_clk(2);
		chk(rssi_q, 8'h5A);
		wr(32'h4000_0204, 32'hFFFF_FFFF);
		rd_chk(32'h4000_0204, 32'h0000_0000);
		end_test("registers");

		// Length source in and out of test mode
		rf_test_mode <= 1'b1;
		wr(`RTT_RF_TEST_OFS, 32'h0000_41FF);
		wait_clk(2);
		chk(tx_len_q, 9'h1FF);
		wr(`RTT_RF_TEST_OFS, 32'h0000_01FF);
		wait_clk(2);
		chk(tx_len_q, 9'h025);
		wr(`RTT_RF_TEST_OFS, 32'h0000_41FF);
		rf_test_mode <= 1'b0;
		wait_clk(2);
		chk(tx_len_q, 9'h025);
		end_test("length");

		// Both generators from a fresh seed, two bytes each
		rf_test_mode <= 1'b1;
		for (int s = 0; s < 2; s++) begin
			wr(`RTT_RF_TEST_OFS, s ? 32'h0000_3000 : 32'h0000_1000);
			new_packet();
			for (int k = 0; k < 2; k++) begin
				req_byte();
				chk(tx_byte_q, ref_byte(s[0]));
			end
		end
		end_test("generator");

		// Endless memory payload repeats a three-byte pattern
		wr(`RTT_RF_TEST_OFS, 32'h0000_8003);
		new_packet();
		for (int k = 0; k < 4; k++) begin
			req_byte();
			chk(pattern_index_q, (k == 2) ? 9'h000 : ((k % 3) + 1));
			chk(tx_byte_q, 8'h3C);
		end
		end_test("pattern");

		// Coarse compare needs the low nibble zero; masked then enabled
		wr(`RTT_IRQ_CLR_OFS, 32'h0000_000F);
		wr(`RTT_COARSE_OFS, 32'h0000_0002);
		base_time_count <= 27'h000_0021;
		wait_clk(3);
		rd_chk(`RTT_IRQ_STS_OFS, 32'h0000_0000);
		base_time_count <= 27'h000_0020;
		wait_clk(3);
		rd_chk(`RTT_IRQ_STS_OFS, 32'h0000_0001);
		chk(irq_q, 1'b0);
		wr(`RTT_IRQ_EN_OFS, 32'h0000_000F);
		wait_clk(2);
		chk(irq_q, 1'b1);
		wr(`RTT_IRQ_CLR_OFS, 32'h0000_0001);
		wait_clk(2);
		chk(irq_q, 1'b0);
		// Precise compare against the whole counter
		wr(`RTT_PRECISE_OFS, 32'h0123_4567);
		base_time_count <= 27'h123_4566;
		wait_clk(3);
		chk(irq_q, 1'b0);
		base_time_count <= 27'h123_4567;
		wait_clk(3);
		chk(irq_q, 1'b1);
		rd_chk(`RTT_IRQ_STS_OFS, 32'h0000_0002);
		wr(`RTT_IRQ_CLR_OFS, 32'h0000_000F);
		end_test("timers");

		// Capture copies the counter and the request bit falls again
		base_time_count <= 27'h2AB_CDEF;
		wr(`RTT_CAPTURE_OFS, 32'h0000_0001);
		// Counter moves only after the capture edge, so the sample is known
		wait_clk(2);
		base_time_count <= 27'h000_0007;
		rd_chk(`RTT_CAPTURE_OFS, 32'h0000_0000);
		rd_chk(`RTT_SAMPLE_OFS, 32'h02AB_CDEF);
		rd_chk(`RTT_IRQ_STS_OFS, 32'h0000_0004);
		wr(`RTT_IRQ_CLR_OFS, 32'h0000_000F);
		end_test("capture");

		// Prefetch gives one pulse when the event distance meets the field
		wr(`RTT_TIMGEN_OFS, 32'h0000_0030);
		pulses = 0;
		@(posedge clk);
		us_to_event <= 16'h0030;
		repeat (6) begin
			@(posedge clk);
			#1;
			if (prefetch_q === 1'b1)
				pulses = pulses + 1;
		end
		chk(pulses, 1);
		rd_chk(`RTT_IRQ_STS_OFS, 32'h0000_0008);
		end_test("prefetch");

		// Wake status holds until power up plus one low-power tick
		@(posedge clk);
		lp_wake_irq <= 1'b1;
		@(posedge clk);
		lp_wake_irq <= 1'b0;
		wait_clk(2);
		chk(lp_wake_status_q, 1'b1);
		rd_chk(`RTT_CTL2_OFS, 32'h0010_0000);
		@(posedge clk);
		lp_clk_tick <= 1'b1;
		@(posedge clk);
		lp_clk_tick <= 1'b0;
		wait_clk(2);
		chk(lp_wake_status_q, 1'b1);
		radio_powered <= 1'b1;
		wait_clk(3);
		chk(lp_wake_status_q, 1'b1);
		// Handler keeps polling; the low-power tick lands after its second read
		polls = 0;
		rdv = 32'h0010_0000;
		while (rdv[`RTT_WAKE_STS_BIT] && polls < 8) begin
			rd_val(`RTT_CTL2_OFS, rdv);
			polls = polls + 1;
			if (polls == 2) begin
				@(posedge clk);
				lp_clk_tick <= 1'b1;
				@(posedge clk);
				lp_clk_tick <= 1'b0;
			end
		end
		chk(polls, 3);
		chk(lp_wake_status_q, 1'b0);
		rd_chk(`RTT_CTL2_OFS, 32'h0000_0000);
		end_test("wake");

		test_done();
	end
endmodule
`default_nettype wire
